// >>> design/slu_rx_end.sv
`timescale 1ns/1ps
`include "slu_params.svh"
module slu_rx_end #(
    parameter bit STREAMING = 1'b0
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Status.
    output logic channelUp,
    output logic softError,
    // Received data.
    output logic [`SLU_DATA_W-1:0] rxData,
    output logic rxValid,
    output logic rxLast,
    // Received priority messages as frames.
    output logic [`SLU_DATA_W-1:0] msgData,
    output logic msgValid,
    output logic msgLast,
    // Rate request toward the partner, kept with the receive side.
    input wire logic rateReq,
    input wire logic [`SLU_IDLE_W-1:0] rateIdles,
    output logic rateAck,
    // Link.
    slu_link_if.rx_end link
);
    // Link capture and channel watch.
    logic [3:0] errCnt;
    logic prevMsg;
    // Last message word seen, delivered one cycle later with its end flag.
    logic [`SLU_DATA_W-1:0] msgHold;
    logic rateOut;
    logic [`SLU_IDLE_W-1:0] idlesOut;
    wire isData = (link.fwdKind == slu_pkg::SLU_K_DATA) ||
        (link.fwdKind == slu_pkg::SLU_K_LAST);
    wire isMsg = (link.fwdKind == slu_pkg::SLU_K_MSG) && !STREAMING;
    wire isInit = (link.fwdKind == slu_pkg::SLU_K_INIT);
    wire rateGo = rateReq && !rateAck && !STREAMING && channelUp;
    assign link.backRate = rateOut;
    assign link.backIdles = idlesOut;
    // Deliver data with control words removed.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxData <= '0;
            rxValid <= 1'b0;
            rxLast <= 1'b0;
            msgData <= '0;
            msgValid <= 1'b0;
            msgLast <= 1'b0;
            prevMsg <= 1'b0;
            msgHold <= '0;
        end else begin
            rxValid <= isData && channelUp;
            rxLast <= (link.fwdKind == slu_pkg::SLU_K_LAST) && !STREAMING;
            rxData <= isData ? link.fwdWord : rxData;
            // A message word is held back one cycle so that its end flag
            // can be set once the next link word shows the message over.
            msgValid <= prevMsg && channelUp;
            msgData <= prevMsg ? msgHold : msgData;
            msgLast <= prevMsg && !isMsg;
            msgHold <= isMsg ? link.fwdWord : msgHold;
            prevMsg <= isMsg;
        end
    end
    // Channel state with error-driven retry.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            channelUp <= 1'b0;
            errCnt <= 4'h0;
            softError <= 1'b0;
        end else begin
            softError <= link.fwdErr;
            if (isInit || errCnt == `SLU_ERR_LIMIT) begin
                channelUp <= 1'b0;
                errCnt <= 4'h0;
            end else begin
                channelUp <= 1'b1;
                errCnt <= errCnt + {3'h0, link.fwdErr};
            end
        end
    end
    // Rate message toward the partner.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rateOut <= 1'b0;
            idlesOut <= 4'h0;
            rateAck <= 1'b0;
        end else begin
            rateAck <= rateGo;
            rateOut <= rateGo ? ~rateOut : 1'b0;
            if (rateGo) begin
                idlesOut <= rateIdles;
            end
        end
    end
endmodule

// >>> design/slu_tx_end.sv
`timescale 1ns/1ps
`include "slu_params.svh"
module slu_tx_end #(
    parameter bit STREAMING = 1'b0,
    parameter bit RATE_IMMEDIATE = 1'b0
) (
    // Clock and reset; the user clock rate follows the lane width.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Channel controls and status.
    input wire logic loopback,
    input wire logic powerDown,
    output logic channelUp,
    // User data port.
    input wire logic [`SLU_DATA_W-1:0] txData,
    input wire logic txValid,
    input wire logic txLast,
    output logic txReady,
    // Priority message request.
    input wire logic msgReq,
    input wire logic [`SLU_MSG_W-1:0] msgLen,
    output logic msgAck,
    // Clock compensation, only on the transmitting end.
    input wire logic clock_comp_request,
    input wire logic clock_comp_warning,
    // Link toward the receiving end, which may be built alone.
    slu_link_if.tx_end link
);
    // Two-entry buffer storage: each entry keeps the end flag above the
    // word, so that a stall on the link side loses nothing.
    logic [`SLU_DATA_W:0] bufMem [0:1];
    // Write and read pointers of the buffer.
    logic wrPtr, rdPtr;
    // Number of entries held, zero to two.
    logic [1:0] bufCount;
    // Transmit control state.
    slu_pkg::slu_tx_state_t state;
    // Training word counter after reset or power-down.
    logic [7:0] initCnt;
    // Idle cycles still to be forced onto the link.
    logic [`SLU_IDLE_W-1:0] idleCnt;
    // Idle count of the last rate message, waiting to be applied.
    logic [`SLU_IDLE_W-1:0] pendIdles;
    // A rate message has arrived and its idles have not started.
    logic ratePend;
    // A frame has started and its last word is not yet sent.
    logic inFrame;
    // Priority message words still to come, less one.
    logic [`SLU_MSG_W-1:0] msgLeft;
    // Back lane rate flag through a short register chain; only the
    // edge detector reads the third stage.
    logic rateS1, rateS2, rateS3;
    // Kind and word chosen for the next link cycle.
    logic [2:0] nextKind;
    logic [`SLU_DATA_W-1:0] nextWord;
    // Buffer fill decode.
    wire bufFull = (bufCount == 2'h2);
    wire bufEmpty = (bufCount == 2'h0);
    // The channel runs once training is over and power is on.
    wire runUp = (state != slu_pkg::SLU_TX_INIT) && !powerDown;
    // One-cycle pulse at the rising edge of the delayed rate flag.
    wire rateEvt = rateS2 && !rateS3;
    // Rate control exists only with the framing interface.
    wire rateOk = !STREAMING;
    // Start the requested idles: at once in immediate mode, otherwise
    // only between frames.
    wire holdForRate = rateOk && ratePend &&
        (RATE_IMMEDIATE || !inFrame);
    // Forced idles hold back the data path.
    wire idling = holdForRate || (idleCnt != 4'h0);
    // A compensation request wins over every other kind of word once the channel runs.
    wire sendComp = clock_comp_request && runUp;
    // The message state steers the data port to the message path.
    wire inMsg = (state == slu_pkg::SLU_TX_MSG);
    // A buffered word leaves when nothing of higher priority is due.
    wire drain = runUp && !sendComp && !idling && !bufEmpty && !inMsg;
    // A message starts only between frames and never under the warning,
    // so that it cannot meet a compensation sequence.
    wire msgGo = runUp && msgReq && !STREAMING && !clock_comp_warning &&
        (state == slu_pkg::SLU_TX_RUN) && !inFrame;
    // Message words are taken straight from the data port.
    wire msgWord = inMsg && txValid && !sendComp;
    // A data word is accepted where valid and ready meet.
    wire push = txValid && txReady;
    // Ready drops at the acknowledge and stays low through the message.
    assign txReady = runUp && !bufFull && !inMsg && !msgAck;
    // Channel status is the running state itself.
    assign channelUp = runUp;
    // Select what goes on the link next.
    always_comb begin
        nextKind = slu_pkg::SLU_K_IDLE;
        nextWord = '0;
        if (!runUp) begin
            nextKind = slu_pkg::SLU_K_INIT;
        end else if (sendComp) begin
            nextKind = slu_pkg::SLU_K_COMP;
        end else if (msgWord) begin
            nextKind = slu_pkg::SLU_K_MSG;
            nextWord = txData;
        end else if (drain) begin
            nextKind = (bufMem[rdPtr][`SLU_DATA_W] && !STREAMING) ?
                slu_pkg::SLU_K_LAST : slu_pkg::SLU_K_DATA;
            nextWord = bufMem[rdPtr][`SLU_DATA_W-1:0];
        end
    end
    // Synchronise the back lane rate flag.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rateS1 <= 1'b0;
            rateS2 <= 1'b0;
            rateS3 <= 1'b0;
        end else begin
            rateS1 <= link.backRate;
            rateS2 <= rateS1;
            rateS3 <= rateS2;
        end
    end
    // Buffer write and read.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            bufCount <= 2'h0;
            bufMem[0] <= '0;
            bufMem[1] <= '0;
        end else begin
            if (push) begin
                bufMem[wrPtr] <= {txLast, txData};
                wrPtr <= ~wrPtr;
            end
            if (drain) begin
                rdPtr <= ~rdPtr;
            end
            bufCount <= bufCount + {1'b0, push} - {1'b0, drain};
        end
    end
    // Channel state, idle insertion and priority messages.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= slu_pkg::SLU_TX_INIT;
            initCnt <= 8'h00;
            idleCnt <= 4'h0;
            pendIdles <= 4'h0;
            ratePend <= 1'b0;
            inFrame <= 1'b0;
            msgAck <= 1'b0;
            msgLeft <= 3'h0;
        end else begin
            // The acknowledge follows the start decision by one cycle.
            msgAck <= msgGo;
            if (rateEvt && rateOk) begin
                ratePend <= 1'b1;
                pendIdles <= link.backIdles;
            end else if (holdForRate) begin
                ratePend <= 1'b0;
                idleCnt <= pendIdles;
            end else if (idleCnt != 4'h0 && !sendComp) begin
                idleCnt <= idleCnt - 4'h1;
            end
            if (drain) begin
                inFrame <= !bufMem[rdPtr][`SLU_DATA_W] || STREAMING;
            end
            // Training, running and message states.
            case (state)
                slu_pkg::SLU_TX_INIT: begin
                    if (!powerDown && !loopback) begin
                        initCnt <= initCnt + 8'h01;
                    end
                    if (initCnt == `SLU_INIT_CYCLES) begin
                        state <= slu_pkg::SLU_TX_RUN;
                    end
                end
                slu_pkg::SLU_TX_RUN: begin
                    if (msgGo) begin
                        state <= slu_pkg::SLU_TX_MSG;
                        msgLeft <= msgLen;
                    end
                end
                slu_pkg::SLU_TX_MSG: begin
                    if (msgWord) begin
                        msgLeft <= msgLeft - 3'h1;
                        if (msgLeft == 3'h0) begin
                            state <= slu_pkg::SLU_TX_RUN;
                        end
                    end
                end
                default: begin
                    state <= slu_pkg::SLU_TX_INIT;
                end
            endcase
            // Power-down returns the channel to training at once.
            if (powerDown) begin
                state <= slu_pkg::SLU_TX_INIT;
                initCnt <= 8'h00;
            end
        end
    end
    // Register the link outputs.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.fwdKind <= slu_pkg::SLU_K_INIT;
            link.fwdWord <= '0;
            link.fwdErr <= 1'b0;
        end else begin
            link.fwdKind <= nextKind;
            link.fwdWord <= nextWord;
            link.fwdErr <= 1'b0;
        end
    end
endmodule

// >>> inc/slu_link_if.sv
`timescale 1ns/1ps
`include "slu_params.svh"
interface slu_link_if;
    // Forward lane: kind and word from transmitter.
    logic [2:0] fwdKind;
    logic [`SLU_DATA_W-1:0] fwdWord;
    logic fwdErr;
    // Back lane: rate messages from receiver to transmitter.
    logic backRate;
    logic [`SLU_IDLE_W-1:0] backIdles;
    modport tx_end (output fwdKind, output fwdWord, output fwdErr,
                    input backRate, input backIdles);
    modport rx_end (input fwdKind, input fwdWord, input fwdErr,
                    output backRate, output backIdles);
endinterface

// >>> inc/slu_params.svh
// Summary of operation
// - Lane count is a build choice, 1 to 24.
// - Lanes 2 or 4 bytes; width lanes times bytes.
// - 2-byte lanes clock twice 4-byte lanes.
// - Full duplex, transmit, receive or both simplex.
// - Completion mode idles wait for frame end.
// - Immediate mode idles start at once.
// - Rate request, acknowledge and 4-bit idle count.
// - Receiver throttles partner with rate messages.
// - Priority message request, acknowledge and length.
// - After acknowledge, ready drops; message words follow.
// - Received priority message delivered as frame.
// - Streaming builds lack priority and rate control.
// - Streaming is one endless frame, valid-qualified.
// - Framed receive strips control and realigns words.
// - Compensation request halts data, sends sequences.
// - Warning keeps messages and compensation apart.
// - Same clock both ends: compensation request low.
// - Compensation interface only in transmitting builds.
// - Simplex keeps only its direction's ports.
// - Reset, loopback, power-down controls; status outputs.
// - Idles fill gaps when no data.
// - Errors reset the channel and retry.
`ifndef SLU_PARAMS_SVH
`define SLU_PARAMS_SVH
`define SLU_LANES 2
`define SLU_LANE_BYTES 2
`define SLU_DATA_W (`SLU_LANES * `SLU_LANE_BYTES * 8)
`define SLU_IDLE_W 4
`define SLU_MSG_W 3
`define SLU_ERR_LIMIT 4'hF
`define SLU_INIT_CYCLES 8'h10
`define SLU_BUF_DEPTH 2
`endif

// >>> inc/slu_pkg.sv
package slu_pkg;
    // Word kinds carried on the modeled link.
    typedef enum logic [2:0] {
        SLU_K_IDLE, SLU_K_DATA, SLU_K_LAST, SLU_K_COMP, SLU_K_RATE, SLU_K_MSG,
        SLU_K_INIT
    } slu_kind_t;
    // Build direction of the transmitting end.
    typedef enum logic [1:0] {
        SLU_DIR_FULL, SLU_DIR_TX, SLU_DIR_RX, SLU_DIR_BOTH
    } slu_dir_t;
    // Transmit states.
    typedef enum logic [1:0] {
        SLU_TX_INIT, SLU_TX_RUN, SLU_TX_MSG
    } slu_tx_state_t;
endpackage

// >>> verification/serial_link_user_interface_tb.sv
`timescale 1ns/1ps
`include "slu_params.svh"
module serial_link_user_interface_tb;
    localparam int W = `SLU_DATA_W;
    // Inputs, all driven from time zero.
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic txValid = 1'b0, txLast = 1'b0, msgReq = 1'b0, rateReq = 1'b0;
    // Both ends share one clock, so compensation rests low and is pulsed
    // only to exercise the halt of data.
    logic compReq = 1'b0, compWarn = 1'b0;
    logic [W-1:0] txData = '0;
    logic [`SLU_MSG_W-1:0] msgLen = '0;
    logic [3:0] rateIdles = '0;
    // Outputs of both ends.
    logic txUp, rxUp, softError, txReady, msgAck, rateAck;
    logic rxValid, rxLast, msgValid, msgLast;
    logic [W-1:0] rxData, msgData;
    // Counters, random state and expected words with their end flag.
    int n_fail = 0, checked = 0, nComp = 0;
    logic [31:0] seed = 32'h9CB8;
    logic [W:0] expQ[$], msgQ[$];
    slu_link_if link ();
    slu_tx_end i_slu_tx_end (.ref_clk(ref_clk), .rst_b(rst_b),
        .loopback(1'b0), .powerDown(1'b0), .channelUp(txUp), .txData(txData),
        .txValid(txValid), .txLast(txLast), .txReady(txReady), .msgReq(msgReq),
        .msgLen(msgLen), .msgAck(msgAck), .clock_comp_request(compReq),
        .clock_comp_warning(compWarn), .link(link));
    slu_rx_end i_slu_rx_end (.ref_clk(ref_clk), .rst_b(rst_b),
        .channelUp(rxUp), .softError(softError), .rxData(rxData),
        .rxValid(rxValid), .rxLast(rxLast), .msgData(msgData),
        .msgValid(msgValid), .msgLast(msgLast), .rateReq(rateReq),
        .rateIdles(rateIdles), .rateAck(rateAck), .link(link));
    slu_link_checker i_slu_link_checker (.ref_clk(ref_clk), .rst_b(rst_b),
        .fwdKind(link.fwdKind), .fwdWord(link.fwdWord), .fwdErr(link.fwdErr),
        .backRate(link.backRate), .backIdles(link.backIdles));
    // The clock toggles every half period of 5 ns.
    always #5 ref_clk = ~ref_clk;
    // Next random value of the shift register.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [W:0] seen,
                       input logic [W:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Waits at falling edges, bounded, until the chosen flag is high:
    // 0 is ready, 1 the message acknowledge, 2 the rate acknowledge.
    task automatic wait_hi(input int sel);
        logic f;
        int n;
        n = 0;
        f = 1'b0;
        while (f !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
            f = (sel == 0) ? txReady : ((sel == 1) ? msgAck : rateAck);
        end
        if (f !== 1'b1) n_fail++;
    endtask
    // Sends one frame of random words; the data holds until taken.
    task automatic frame(input int len);
        for (int i = 0; i < len; i++) begin
            seed = lfsr(seed);
            expQ.push_back({i == len - 1, W'(seed)});
            txData <= W'(seed);
            txValid <= 1'b1;
            txLast <= (i == len - 1);
            wait_hi(0);
            @(posedge ref_clk);
        end
        txValid <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Priority message, first held off by the warning input.
    task automatic message();
        seed = lfsr(seed);
        compWarn <= 1'b1;
        msgReq <= 1'b1;
        msgLen <= seed[2:0];
        repeat (3) @(negedge ref_clk);
        chk("ack under warning", msgAck, 1'b0);
        @(posedge ref_clk);
        compWarn <= 1'b0;
        wait_hi(1);
        chk("ready after ack", txReady, 1'b0);
        @(posedge ref_clk);
        msgReq <= 1'b0;
        for (int i = 0; i <= int'(msgLen); i++) begin
            seed = lfsr(seed);
            msgQ.push_back({i == int'(msgLen), W'(seed)});
            txData <= W'(seed);
            txValid <= 1'b1;
            @(posedge ref_clk);
        end
        txValid <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Rate request held until acknowledged, then released.
    task automatic rate();
        rateReq <= 1'b1;
        rateIdles <= (seed[0]) ? 4'hF : seed[7:4];
        wait_hi(2);
        @(posedge ref_clk);
        rateReq <= 1'b0;
        @(negedge ref_clk);
        chk("ack one cycle", rateAck, 1'b0);
        @(posedge ref_clk);
    endtask
    // Receive monitors compare every delivered word in order.
    always @(posedge ref_clk) begin
        if (rxValid === 1'b1) begin
            chk("rx word", {rxLast, rxData},
                expQ.size() ? expQ.pop_front() : 'x);
        end
        if (msgValid === 1'b1) begin
            chk("msg word", {msgLast, msgData},
                msgQ.size() ? msgQ.pop_front() : 'x);
        end
        if (link.fwdKind === slu_pkg::SLU_K_COMP) nComp++;
    end
    // Main sequence: reset, init, then mixed traffic.
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk("ready in init", txReady, 1'b0);
        repeat (30) @(posedge ref_clk);
        chk("tx up", txUp, 1'b1);
        chk("rx up", rxUp, 1'b1);
        frame(1);
        frame(1);
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            if (k % 4 == 0) message();
            if (k % 4 == 1) rate();
            if (k % 4 == 2) begin
                fork
                    begin
                        compReq <= 1'b1;
                        repeat (4) @(posedge ref_clk);
                        compReq <= 1'b0;
                    end
                join_none
            end
            frame(1 + int'(seed[2:0]));
        end
        for (int n = 0; n < 500 && (expQ.size() + msgQ.size()) > 0; n++)
            @(posedge ref_clk);
        chk("words left", expQ.size() + msgQ.size(), 0);
        chk("comp seen", nComp != 0, 1'b1);
        chk("soft error", softError, 1'b0);
        final_report();
    end
    // Watchdog: about fifty times the expected run length.
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule

// >>> verification/slu_link_checker.sv
`timescale 1ns/1ps
`include "slu_params.svh"
module slu_link_checker (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Link signals between the two ends.
    input wire logic [2:0] fwdKind,
    input wire logic [`SLU_DATA_W-1:0] fwdWord,
    input wire logic fwdErr,
    input wire logic backRate,
    input wire logic [`SLU_IDLE_W-1:0] backIdles
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Training words after reset, and a short run of idles.
    sequence s_init; (fwdKind == slu_pkg::SLU_K_INIT) [*8]; endsequence
    sequence s_idle2; (fwdKind == slu_pkg::SLU_K_IDLE) [*2]; endsequence
    // A long rate request must give a long unbroken run of idles.
    sequence s_idle8; (fwdKind == slu_pkg::SLU_K_IDLE) [*8]; endsequence
    property p_init; $rose(rst_b) |-> s_init; endproperty
    property p_quiet; $rose(rst_b) |-> !backRate; endproperty
    property p_no_err; fwdErr == 1'b0; endproperty
    property p_legal; fwdKind <= 3'(slu_pkg::SLU_K_INIT); endproperty
    property p_pulse; backRate |=> !backRate; endproperty
    property p_stay_up;
        fwdKind != slu_pkg::SLU_K_INIT |=> fwdKind != slu_pkg::SLU_K_INIT;
    endproperty
    property p_throttle;
        backRate && backIdles != 4'h0 |-> ##[1:300] s_idle2;
    endproperty
    property p_idle_run; backRate && backIdles == 4'hF |-> ##[1:300] s_idle8;
    endproperty
    a_init: assert property (p_init) else $error("no init words");
    a_quiet: assert property (p_quiet) else $error("rate at reset");
    a_no_err: assert property (p_no_err) else $error("link error");
    a_legal: assert property (p_legal) else $error("bad kind");
    a_pulse: assert property (p_pulse) else $error("rate too long");
    a_stay_up: assert property (p_stay_up) else $error("reinit");
    a_throttle: assert property (p_throttle) else $error("no idles");
    a_idle_run: assert property (p_idle_run) else $error("no idle run");
endmodule
